// File: urt_pkg.sv
package urt_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_COUNT = 4'h4;
    localparam logic [3:0] ADDR_IRQ = 4'h8;

    // ----------------------------------------
    // Mode register layout
    // ----------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h18;
    localparam logic [7:0] MODE_FIXED = 8'h18;
    localparam logic [7:0] MODE_WMASK = 8'hE7;
    localparam int MODE_RELOAD_BIT = 7;
    localparam int MODE_HWDIR_BIT = 6;
    localparam int MODE_SWDOWN_BIT = 5;
    localparam int CSEL_MSB = 2;
    localparam int CSEL_LSB = 0;

    // ----------------------------------------
    // Clock select codes
    // ----------------------------------------
    localparam logic [2:0] CSEL_SUB4 = 3'h6;
    localparam logic [2:0] CSEL_EVENT = 3'h7;
    localparam int PRESC_N = 6;

    // ----------------------------------------
    // Interrupt register layout
    // ----------------------------------------
    localparam int IRQ_FLAG_BIT = 0;
    localparam int IRQ_EN_BIT = 1;

    // ----------------------------------------
    // Counter values
    // ----------------------------------------
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_MIN = 8'h00;
    localparam logic [7:0] STEP_ONE = 8'h01;
    localparam logic [7:0] STEP_TWO = 8'h02;

    // ----------------------------------------
    // Bus responses
    // ----------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {
        URT_UP,
        URT_DOWN
    } urt_dir_t;

endpackage : urt_pkg

// File: urt_timer.sv
// What this block does
// - Mode bit 7 selects interval timer (0) or auto-reload timer (1).
// - Direction bits 6..5: 00 up, 01 down, 1x direction pin decides.
// - With hardware direction, pin high counts down, pin low counts up.
// - Mode bits 4 and 3 always read 1; writes to them ignored.
// - Clock select picks /8192,/2048,/512,/64,/16,/4, subclock/4 or events.
// - Event mode steps once per selected event-pin edge, current direction.
// - 8-bit counter readable any time without disturbance; never written directly.
// - Overflow past FF or underflow past 00 sets the interrupt flag.
// - Interrupt request raised while flag and enable are both 1.
// - Interval mode wraps to 00 or FF and keeps counting same way.
// - Any reload register write copies the value into the counter at once.
// - Auto-reload mode loads reload value on wrap; period 1 to 256 clocks.
// - One shared address: reads return counter, writes go to reload.
// - Reset clears counter and reload, mode to 18; counts up on /8192.
// - In low-power sub modes only subclock/4 or events advance the counter.
// - Subclock/4 passes a synchronizer; up to one system clock jitter.
// - Subclock/4 with watch/8 subclock moves two lowest bits, LSB not counted.
module urt_timer #(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    // AXI4-Lite write response
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    // AXI4-Lite read data
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    // Count sources, same clock domain
    input wire logic [urt_pkg::PRESC_N-1:0] presc_tick_i,
    input wire logic event_edge_select_i,
    input wire logic low_power_mode_i,
    input wire logic sub_div8_i,
    // Asynchronous pins
    input wire logic subclk_div4_i,
    input wire logic event_in_pin_i,
    input wire logic direction_pin_i,
    // Interrupt request
    output logic cpu_irq_o
);

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [3:0] off);
        addr_is = (a == ADDR_W'(off));
    endfunction : addr_is

    // ----------------------------------------
    // Bus write path
    // ----------------------------------------
    logic aw_rdy_r, w_rdy_r, aw_full_r, w_full_r, bvalid_r;
    logic [1:0] bresp_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic aw_take, w_take, do_wr, aw_full_nxt, w_full_nxt, bvalid_nxt, wr_hit;

    assign aw_take = s_axi_awvalid_i & aw_rdy_r;
    assign w_take = s_axi_wvalid_i & w_rdy_r;
    assign do_wr = aw_full_r & w_full_r & ~bvalid_r;
    assign aw_full_nxt = (aw_full_r | aw_take) & ~do_wr;
    assign w_full_nxt = (w_full_r | w_take) & ~do_wr;
    assign bvalid_nxt = do_wr | (bvalid_r & ~s_axi_bready_i);
    assign wr_hit = addr_is(aw_addr_r, urt_pkg::ADDR_MODE) | addr_is(aw_addr_r, urt_pkg::ADDR_COUNT)
                  | addr_is(aw_addr_r, urt_pkg::ADDR_IRQ);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b0;
            aw_rdy_r <= 1'b0;
            w_rdy_r <= 1'b0;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            bvalid_r <= bvalid_nxt;
            // Ready only while the holding slot is empty and no response waits
            aw_rdy_r <= ~aw_full_nxt & ~bvalid_nxt & ~do_wr;
            w_rdy_r <= ~w_full_nxt & ~bvalid_nxt & ~do_wr;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_addr_r <= '0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bresp_r <= urt_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr_r <= s_axi_awaddr_i;
            end
            if (w_take) begin
                w_data_r <= s_axi_wdata_i;
                w_strb_r <= s_axi_wstrb_i;
            end
            if (do_wr) begin
                bresp_r <= wr_hit ? urt_pkg::RESP_OKAY : urt_pkg::RESP_SLVERR;
            end
        end
    end

    // Only the low byte lane carries register bits
    logic wr_lane0;
    logic mode_wr;
    logic reload_wr;
    logic irq_wr;

    assign wr_lane0 = do_wr & w_strb_r[0];
    assign mode_wr = wr_lane0 & addr_is(aw_addr_r, urt_pkg::ADDR_MODE);
    assign reload_wr = wr_lane0 & addr_is(aw_addr_r, urt_pkg::ADDR_COUNT);
    assign irq_wr = wr_lane0 & addr_is(aw_addr_r, urt_pkg::ADDR_IRQ);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] mode_r;
    logic [7:0] reload_r;
    logic [7:0] count_r;
    logic irq_en_r;
    logic irq_flag_r;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_r <= urt_pkg::MODE_RESET;
        end else if (mode_wr) begin
            mode_r <= (w_data_r[7:0] & urt_pkg::MODE_WMASK) | urt_pkg::MODE_FIXED;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reload_r <= urt_pkg::RELOAD_RESET;
        end else if (reload_wr) begin
            reload_r <= w_data_r[7:0];
        end
    end

    // ----------------------------------------
    // Pin synchronizers
    // ----------------------------------------
    logic sub_s1_r, sub_s2_r, sub_s3_r;
    logic evt_s1_r, evt_s2_r, evt_s3_r;
    logic dir_s1_r, dir_s2_r;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sub_s1_r <= 1'b0;
            sub_s2_r <= 1'b0;
            sub_s3_r <= 1'b0;
            evt_s1_r <= 1'b0;
            evt_s2_r <= 1'b0;
            evt_s3_r <= 1'b0;
            dir_s1_r <= 1'b0;
            dir_s2_r <= 1'b0;
        end else begin
            sub_s1_r <= subclk_div4_i;
            sub_s2_r <= sub_s1_r;
            sub_s3_r <= sub_s2_r;
            evt_s1_r <= event_in_pin_i;
            evt_s2_r <= evt_s1_r;
            evt_s3_r <= evt_s2_r;
            dir_s1_r <= direction_pin_i;
            dir_s2_r <= dir_s1_r;
        end
    end

    // ----------------------------------------
    // Count source and direction
    // ----------------------------------------
    logic [2:0] csel;
    logic sub_edge;
    logic evt_edge;
    logic step;
    urt_pkg::urt_dir_t dir;
    logic [7:0] amount;
    logic [8:0] sum9;
    logic [8:0] diff9;
    logic [7:0] count_step;
    logic wrap;

    assign csel = mode_r[urt_pkg::CSEL_MSB:urt_pkg::CSEL_LSB];
    // Edge taken between stages two and three; stage one stays private
    assign sub_edge = sub_s2_r & ~sub_s3_r;
    assign evt_edge = event_edge_select_i ? (evt_s2_r & ~evt_s3_r) : (~evt_s2_r & evt_s3_r);

    always_comb begin
        step = 1'b0;
        unique case (csel)
            urt_pkg::CSEL_SUB4: step = sub_edge;
            urt_pkg::CSEL_EVENT: step = evt_edge;
            default: step = presc_tick_i[csel] & ~low_power_mode_i;
        endcase
    end

    always_comb begin
        if (mode_r[urt_pkg::MODE_HWDIR_BIT]) begin
            dir = dir_s2_r ? urt_pkg::URT_DOWN : urt_pkg::URT_UP;
        end else begin
            dir = mode_r[urt_pkg::MODE_SWDOWN_BIT] ? urt_pkg::URT_DOWN : urt_pkg::URT_UP;
        end
    end

    // Slow subclock stepping by two mirrors the lost LSB
    assign amount = (csel == urt_pkg::CSEL_SUB4 && sub_div8_i) ? urt_pkg::STEP_TWO : urt_pkg::STEP_ONE;
    assign sum9 = {1'b0, count_r} + {1'b0, amount};
    assign diff9 = {1'b0, count_r} - {1'b0, amount};

    always_comb begin
        if (dir == urt_pkg::URT_DOWN) begin
            count_step = diff9[7:0];
            wrap = diff9[8];
        end else begin
            count_step = sum9[7:0];
            wrap = sum9[8];
        end
    end

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    logic wrap_evt;

    // A reload register write swallows a step landing in the same cycle
    assign wrap_evt = step & wrap & ~reload_wr;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_r <= urt_pkg::COUNT_RESET;
        end else if (reload_wr) begin
            count_r <= w_data_r[7:0];
        end else if (step) begin
            if (wrap && mode_r[urt_pkg::MODE_RELOAD_BIT]) begin
                count_r <= reload_r;
            end else begin
                count_r <= count_step;
            end
        end
    end

    // ----------------------------------------
    // Interrupt flag and request
    // ----------------------------------------
    logic flag_clr;
    logic flag_nxt;
    logic en_nxt;

    assign flag_clr = irq_wr & w_data_r[urt_pkg::IRQ_FLAG_BIT];
    assign flag_nxt = (irq_flag_r & ~flag_clr) | wrap_evt;
    assign en_nxt = irq_wr ? w_data_r[urt_pkg::IRQ_EN_BIT] : irq_en_r;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_flag_r <= 1'b0;
            irq_en_r <= 1'b0;
            cpu_irq_o <= 1'b0;
        end else begin
            irq_flag_r <= flag_nxt;
            irq_en_r <= en_nxt;
            cpu_irq_o <= flag_nxt & en_nxt;
        end
    end

    // ----------------------------------------
    // Bus read path
    // ----------------------------------------
    logic ar_rdy_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic ar_take;
    logic rvalid_nxt;

    assign ar_take = s_axi_arvalid_i & ar_rdy_r;
    assign rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready_i);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ar_rdy_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= urt_pkg::RESP_OKAY;
        end else begin
            ar_rdy_r <= ~rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (ar_take) begin
                rresp_r <= urt_pkg::RESP_OKAY;
                if (addr_is(s_axi_araddr_i, urt_pkg::ADDR_MODE)) begin
                    rdata_r <= {24'h00_0000, mode_r};
                end else if (addr_is(s_axi_araddr_i, urt_pkg::ADDR_COUNT)) begin
                    rdata_r <= {24'h00_0000, count_r};
                end else if (addr_is(s_axi_araddr_i, urt_pkg::ADDR_IRQ)) begin
                    rdata_r <= {30'h0000_0000, irq_en_r, irq_flag_r};
                end else begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= urt_pkg::RESP_SLVERR;
                end
            end
        end
    end

    assign s_axi_awready_o = aw_rdy_r;
    assign s_axi_wready_o = w_rdy_r;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_arready_o = ar_rdy_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o = rdata_r;
    assign s_axi_rresp_o = rresp_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_mode_fixed;
        (mode_r & urt_pkg::MODE_FIXED) == urt_pkg::MODE_FIXED;
    endproperty
    a_mode_fixed: assert property (p_mode_fixed) else $error("mode bits 4..3 not one");
    property p_reload_copy;
        reload_wr |=> (count_r == $past(w_data_r[7:0])) && (reload_r == count_r);
    endproperty
    a_reload_copy: assert property (p_reload_copy) else $error("reload write not copied");
    property p_write_beats_step;
        (reload_wr && step) |=> !irq_flag_r || $past(irq_flag_r) || $past(flag_clr);
    endproperty
    a_write_beats_step: assert property (p_write_beats_step) else $error("step not swallowed");
    property p_interval_wrap;
        (step && wrap && !reload_wr && !mode_r[urt_pkg::MODE_RELOAD_BIT] && amount == urt_pkg::STEP_ONE)
            |=> count_r == (($past(dir) == urt_pkg::URT_DOWN) ? urt_pkg::CNT_MAX : urt_pkg::CNT_MIN);
    endproperty
    a_interval_wrap: assert property (p_interval_wrap) else $error("interval wrap wrong");
    property p_auto_reload;
        (step && wrap && !reload_wr && mode_r[urt_pkg::MODE_RELOAD_BIT]) |=> count_r == $past(reload_r);
    endproperty
    a_auto_reload: assert property (p_auto_reload) else $error("auto reload missed");
    property p_flag_set;
        (step && wrap && !reload_wr) |=> irq_flag_r;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set on wrap");
    property p_irq_out;
        cpu_irq_o == (irq_flag_r && irq_en_r);
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("irq output mismatch");
    property p_halt_low_power;
        (low_power_mode_i && csel != urt_pkg::CSEL_SUB4 && csel != urt_pkg::CSEL_EVENT && !reload_wr)
            |=> $stable(count_r);
    endproperty
    a_halt_low_power: assert property (p_halt_low_power) else $error("counted while halted");
    property p_hw_down;
        (mode_r[urt_pkg::MODE_HWDIR_BIT] && dir_s2_r && step && !wrap && !reload_wr && amount == urt_pkg::STEP_ONE)
            |=> count_r == $past(count_r) - urt_pkg::STEP_ONE;
    endproperty
    a_hw_down: assert property (p_hw_down) else $error("hw down count wrong");
    property p_event_edge;
        (csel == urt_pkg::CSEL_EVENT && step) |-> $changed(evt_s2_r);
    endproperty
    a_event_edge: assert property (p_event_edge) else $error("event step without edge");
    property p_rvalid_hold;
        (rvalid_r && !s_axi_rready_i) |=> rvalid_r && $stable(rdata_r);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");

    c_reload_wrap: cover property (step && wrap && mode_r[urt_pkg::MODE_RELOAD_BIT] && !reload_wr);
    c_underflow: cover property (step && wrap && dir == urt_pkg::URT_DOWN);
    c_event_step: cover property (csel == urt_pkg::CSEL_EVENT && step);
    c_irq: cover property (!cpu_irq_o ##1 cpu_irq_o);

endmodule : urt_timer

// File: urt_far_model.sv
module urt_far_model (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Commands
    input wire logic go_i,
    input wire logic [7:0] cnt_i,
    input wire logic to_sub_i,
    input wire logic dir_i,
    // Pins
    output logic event_in_pin_o,
    output logic subclk_div4_o,
    output logic direction_pin_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] half_r;
    logic [1:0] pace_r;
    logic lvl_r;
    // ----------------------------------------
    // Pulse train, 4 cycles per half period
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            half_r <= 9'h000;
            pace_r <= 2'h0;
            lvl_r <= 1'b0;
        end else if (go_i) begin
            half_r <= {cnt_i, 1'b0};
            pace_r <= 2'h0;
        end else if (half_r != 9'h000) begin
            pace_r <= pace_r + 2'h1;
            if (pace_r == 2'h3) begin
                lvl_r <= ~lvl_r;
                half_r <= half_r - 9'h001;
            end
        end
    end
    // Idle low between bursts, so a source clock stands still outside them
    assign event_in_pin_o = lvl_r & ~to_sub_i;
    assign subclk_div4_o = lvl_r & to_sub_i;
    assign direction_pin_o = dir_i;
    assign busy_o = (half_r != 9'h000);
endmodule : urt_far_model

// File: tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, awv, wv, bry, arv, rry, esel, lowp, div8, go, tosub, dir, busy;
    logic awr, wr_o, bv, arr, rv, irq, evp, subp, dirp;
    logic [3:0] awa, ara;
    logic [31:0] wd, rd;
    logic [1:0] br, rr;
    logic [5:0] tk;
    logic [7:0] gcnt;
    int mismatches, samples_checked;
    urt_timer u_urt_timer (.ref_clk_i(clk), .rst_i(rst), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_o), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_bresp_o(br),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rry), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .presc_tick_i(tk),
        .event_edge_select_i(esel), .low_power_mode_i(lowp), .sub_div8_i(div8), .subclk_div4_i(subp),
        .event_in_pin_i(evp), .direction_pin_i(dirp), .cpu_irq_o(irq));
    urt_far_model u_urt_far_model (.ref_clk_i(clk), .rst_i(rst), .go_i(go), .cnt_i(gcnt), .to_sub_i(tosub),
        .dir_i(dir), .event_in_pin_o(evp), .subclk_div4_o(subp), .direction_pin_o(dirp), .busy_o(busy));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic wrap_up();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    // Payload held until its own ready; response ready held until bvalid
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er = urt_pkg::RESP_OKAY);
        int n;
        n = 0;
        awa <= a;
        wd <= {24'h000000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        while (n < 200) begin
            @(posedge clk);
            n++;
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_o) wv <= 1'b0;
            if (bv) break;
        end
        chk({31'h0, bv}, 32'h1, "bvalid timeout");
        chk({30'h0, br}, {30'h0, er}, "bresp");
    endtask : wr
    task automatic rdc(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er = urt_pkg::RESP_OKAY);
        int n;
        n = 0;
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        while (n < 200) begin
            @(posedge clk);
            n++;
            if (arv && arr) arv <= 1'b0;
            if (rv) break;
        end
        chk({31'h0, rv}, 32'h1, "rvalid timeout");
        chk(rd, {24'h000000, e}, "rdata");
        chk({30'h0, rr}, {30'h0, er}, "rresp");
    endtask : rdc
    task automatic tick(input int j);
        tk <= 6'h01 << j;
        @(posedge clk);
        tk <= 6'h00;
        @(posedge clk);
    endtask : tick
    task automatic burst(input logic [7:0] n, input logic s);
        int w;
        w = 0;
        gcnt <= n;
        tosub <= s;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy && w < 3000) begin
            @(posedge clk);
            w++;
        end
        chk({31'h0, busy}, 32'h0, "burst timeout");
        repeat (8) @(posedge clk);
    endtask : burst
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rdc(urt_pkg::ADDR_MODE, 8'h18);
        rdc(urt_pkg::ADDR_COUNT, 8'h00);
        rdc(urt_pkg::ADDR_IRQ, 8'h00);
        tick(0);
        rdc(urt_pkg::ADDR_COUNT, 8'h01);
        wr(urt_pkg::ADDR_MODE, 8'h00);
        rdc(urt_pkg::ADDR_MODE, 8'h18);
        wr(urt_pkg::ADDR_MODE, 8'hE7);
        rdc(urt_pkg::ADDR_MODE, 8'hFF);
    endtask : t_reset
    task automatic t_csel();
        for (int k = 0; k < 6; k++) begin
            wr(urt_pkg::ADDR_MODE, 8'h18 | 8'(k));
            wr(urt_pkg::ADDR_COUNT, 8'h00);
            for (int j = 0; j < 6; j++) tick(j);
            rdc(urt_pkg::ADDR_COUNT, 8'h01);
        end
    endtask : t_csel
    task automatic t_shared();
        wr(urt_pkg::ADDR_MODE, 8'h18);
        wr(urt_pkg::ADDR_COUNT, 8'hA5);
        rdc(urt_pkg::ADDR_COUNT, 8'hA5);
        rdc(urt_pkg::ADDR_COUNT, 8'hA5);
        fork
            wr(urt_pkg::ADDR_COUNT, 8'h40);
            begin
                @(posedge clk);
                tk <= 6'h01;
                @(posedge clk);
                tk <= 6'h00;
            end
        join
        rdc(urt_pkg::ADDR_COUNT, 8'h40);
    endtask : t_shared
    task automatic t_wrap_irq();
        wr(urt_pkg::ADDR_MODE, 8'h38);
        wr(urt_pkg::ADDR_COUNT, 8'h01);
        tick(0);
        tick(0);
        rdc(urt_pkg::ADDR_COUNT, 8'hFF);
        rdc(urt_pkg::ADDR_IRQ, 8'h01);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(urt_pkg::ADDR_IRQ, 8'h02);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1, "irq on");
        wr(urt_pkg::ADDR_IRQ, 8'h03);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0, "irq clr");
        wr(urt_pkg::ADDR_MODE, 8'h18);
        wr(urt_pkg::ADDR_COUNT, 8'hFF);
        tick(0);
        rdc(urt_pkg::ADDR_COUNT, 8'h00);
        chk({31'h0, irq}, 32'h1, "irq ovf");
        wr(urt_pkg::ADDR_IRQ, 8'h01);
    endtask : t_wrap_irq
    task automatic t_hwdir();
        dir <= 1'b1;
        wr(urt_pkg::ADDR_MODE, 8'h58);
        repeat (8) @(posedge clk);
        wr(urt_pkg::ADDR_COUNT, 8'h10);
        tick(0);
        rdc(urt_pkg::ADDR_COUNT, 8'h0F);
        dir <= 1'b0;
        repeat (8) @(posedge clk);
        wr(urt_pkg::ADDR_MODE, 8'h78);
        tick(0);
        rdc(urt_pkg::ADDR_COUNT, 8'h10);
    endtask : t_hwdir
    task automatic t_reload();
        wr(urt_pkg::ADDR_MODE, 8'h98);
        wr(urt_pkg::ADDR_COUNT, 8'hFE);
        tick(0);
        tick(0);
        rdc(urt_pkg::ADDR_COUNT, 8'hFE);
        rdc(urt_pkg::ADDR_IRQ, 8'h01);
        wr(urt_pkg::ADDR_IRQ, 8'h01);
        wr(urt_pkg::ADDR_MODE, 8'hB8);
        wr(urt_pkg::ADDR_COUNT, 8'h01);
        tick(0);
        tick(0);
        rdc(urt_pkg::ADDR_COUNT, 8'h01);
        wr(urt_pkg::ADDR_IRQ, 8'h01);
    endtask : t_reload
    task automatic t_events();
        esel <= 1'b1;
        wr(urt_pkg::ADDR_MODE, 8'h1F);
        wr(urt_pkg::ADDR_COUNT, 8'h00);
        burst(8'h05, 1'b0);
        rdc(urt_pkg::ADDR_COUNT, 8'h05);
        esel <= 1'b0;
        wr(urt_pkg::ADDR_COUNT, 8'h00);
        burst(8'h03, 1'b0);
        rdc(urt_pkg::ADDR_COUNT, 8'h03);
    endtask : t_events
    task automatic t_sub();
        wr(urt_pkg::ADDR_MODE, 8'h1E);
        wr(urt_pkg::ADDR_COUNT, 8'h00);
        burst(8'h04, 1'b1);
        rdc(urt_pkg::ADDR_COUNT, 8'h04);
        div8 <= 1'b1;
        wr(urt_pkg::ADDR_COUNT, 8'h00);
        burst(8'h03, 1'b1);
        rdc(urt_pkg::ADDR_COUNT, 8'h06);
        div8 <= 1'b0;
        lowp <= 1'b1;
        wr(urt_pkg::ADDR_COUNT, 8'h00);
        burst(8'h02, 1'b1);
        rdc(urt_pkg::ADDR_COUNT, 8'h02);
        wr(urt_pkg::ADDR_MODE, 8'h18);
        tick(0);
        rdc(urt_pkg::ADDR_COUNT, 8'h02);
        lowp <= 1'b0;
        rdc(4'hC, 8'h00, urt_pkg::RESP_SLVERR);
        wr(4'hC, 8'h55, urt_pkg::RESP_SLVERR);
    endtask : t_sub
    // ----------------------------------------
    // Clock, reset, sequence, watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {awv, wv, bry, arv, rry, esel, lowp, div8, go, tosub, dir} = '0;
        awa = 4'h0;
        ara = 4'h0;
        wd = 32'h0;
        tk = 6'h00;
        gcnt = 8'h00;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_csel();
        t_shared();
        t_wrap_irq();
        t_hwdir();
        t_reload();
        t_events();
        t_sub();
        wrap_up();
    end
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule : tb
